// *** lpbd_pkg.sv ***
package lpbd_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;

    // Register byte addresses
    localparam logic [15:0] ADDR_REF_PWR   = 16'h2050;
    localparam logic [15:0] ADDR_TIA_CFG   = 16'h20ec;
    localparam logic [15:0] ADDR_LOOP_SW   = 16'h20e4;
    localparam logic [15:0] ADDR_DAC_CODES = 16'h2120;
    localparam logic [15:0] ADDR_DAC_CTRL  = 16'h2128;
    localparam logic [15:0] ADDR_CM_SW     = 16'h235c;

    // Bias DAC code fields
    localparam int unsigned COARSE_LSB = 12;
    localparam int unsigned COARSE_W   = 6;
    localparam int unsigned FINE_LSB   = 0;
    localparam int unsigned FINE_W     = 12;
    localparam logic [5:0]  COARSE_MAX = 6'h3f;
    localparam logic [11:0] FINE_MAX   = 12'hfff;

    // Reference power control bits
    localparam int unsigned BANDGAP_PD_BIT = 0;
    localparam int unsigned REFBUF_PD_BIT  = 1;

    // Common-mode switch bit
    localparam int unsigned CM_ENABLE_BIT = 3;

    // DAC control bits
    localparam int unsigned DAC_WE_BIT = 0;

    // Transimpedance amplifier fields
    localparam int unsigned GAIN_LSB = 5;
    localparam int unsigned GAIN_W   = 5;

    // Loop switch layout
    localparam int unsigned LOOP_SW_N      = 14;
    localparam int unsigned DIODE_SW_BIT   = 0;
    localparam int unsigned PSTAT_FB_BIT   = 10;
    localparam logic [13:0] FORCE_SENSE_SW = 14'h000c;

    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    // Bias voltage scaling, microvolts
    localparam int unsigned V_W          = 22;
    localparam logic [39:0] V_ZERO_UV    = 40'h00_0003_0d40; // 0.2 V
    localparam logic [39:0] COARSE_SPAN  = 40'h00_0021_0cf0; // 2.166 V
    localparam logic [39:0] COARSE_STEPS = 40'h00_0000_003f;
    localparam logic [39:0] FINE_SPAN    = 40'h00_0021_91c0; // 2.2 V
    localparam logic [39:0] FINE_STEPS   = 40'h00_0000_0fff;

    // Analog-side controls carried together
    typedef struct packed {
        logic [5:0]  coarse_bias_code;
        logic [11:0] fine_bias_code;
        logic [21:0] coarse_bias_uv;
        logic [21:0] fine_bias_uv;
        logic        ref_buffer_powerdown;
        logic        bandgap_powerdown;
        logic        common_mode_resistor_enable;
        logic [4:0]  gain_resistor_select;
        logic [13:0] amp_loop_switches;
        logic        diode_clamp_switch;
        logic        potentiostat_feedback_switch;
    } lpbd_analog_s;

endpackage

// *** lpbd_regs.sv ***
// Contract
// - Coarse bias code held in bits 17:12
// - Coarse output spans 0.2 V to 2.366 V
// - Fine bias code held in bits 11:0
// - Fine output spans 0.2 V to 2.4 V
// - Bit 1 powers down reference buffer
// - Bit 0 powers down low-power bandgap
// - Bit 3 closes common-mode resistor switches
// - Nonzero gain field closes force/sense switches
// - Loop switch bit 0 connects clamp diodes
// - Feedback switch makes potentiostat a buffer
// - Write enable clear: codes ignored, zero
// - Loop switch bit n drives switch n
//
// Design decision made here: strobed register access.
module lpbd_regs (
    input  wire logic                 i_clk,
    input  wire logic                 i_nrst,
    input  wire logic [15:0]          i_addr,
    input  wire logic [31:0]          i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic [31:0]               o_rdata,
    output lpbd_pkg::lpbd_analog_s    o_analog
);

    // Address match, used by both write and read decode
    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] r);
        hit = (a == r);
    endfunction

    // Software-visible state
    logic [5:0]  coarse_q;
    logic [11:0] fine_q;
    logic        dac_we_q;
    logic        refbuf_pd_q;
    logic        bandgap_pd_q;
    logic        cm_en_q;
    logic [4:0]  gain_q;
    logic [13:0] loop_sw_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Derived analog controls
    logic [13:0] loop_sw_d;
    logic [21:0] coarse_uv_d;
    logic [21:0] fine_uv_d;
    logic [39:0] coarse_prod;
    logic [39:0] fine_prod;
    lpbd_pkg::lpbd_analog_s analog_q;

    // Write strobes per register
    logic wr_dac_codes;
    logic wr_dac_ctrl;
    logic wr_ref_pwr;
    logic wr_cm_sw;
    logic wr_tia_cfg;
    logic wr_loop_sw;

    assign wr_dac_codes = i_wr & hit(i_addr, lpbd_pkg::ADDR_DAC_CODES);
    assign wr_dac_ctrl  = i_wr & hit(i_addr, lpbd_pkg::ADDR_DAC_CTRL);
    assign wr_ref_pwr   = i_wr & hit(i_addr, lpbd_pkg::ADDR_REF_PWR);
    assign wr_cm_sw     = i_wr & hit(i_addr, lpbd_pkg::ADDR_CM_SW);
    assign wr_tia_cfg   = i_wr & hit(i_addr, lpbd_pkg::ADDR_TIA_CFG);
    assign wr_loop_sw   = i_wr & hit(i_addr, lpbd_pkg::ADDR_LOOP_SW);

    // DAC write enable
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            dac_we_q <= 1'b0;
        end else if (wr_dac_ctrl) begin
            dac_we_q <= i_wdata[lpbd_pkg::DAC_WE_BIT];
        end
    end

    // Bias DAC codes, forced to zero while writes are disabled
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            coarse_q <= 6'h00;
            fine_q   <= 12'h000;
        end else if (!dac_we_q) begin
            coarse_q <= 6'h00;
            fine_q   <= 12'h000;
        end else if (wr_dac_codes) begin
            coarse_q <= i_wdata[lpbd_pkg::COARSE_LSB +: lpbd_pkg::COARSE_W];
            fine_q   <= i_wdata[lpbd_pkg::FINE_LSB +: lpbd_pkg::FINE_W];
        end
    end

    // Reference power-down bits
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            refbuf_pd_q  <= 1'b0;
            bandgap_pd_q <= 1'b0;
        end else if (wr_ref_pwr) begin
            refbuf_pd_q  <= i_wdata[lpbd_pkg::REFBUF_PD_BIT];
            bandgap_pd_q <= i_wdata[lpbd_pkg::BANDGAP_PD_BIT];
        end
    end

    // Common-mode resistor switch enable
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            cm_en_q <= 1'b0;
        end else if (wr_cm_sw) begin
            cm_en_q <= i_wdata[lpbd_pkg::CM_ENABLE_BIT];
        end
    end

    // Transimpedance amplifier gain resistor select
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            gain_q <= 5'h00;
        end else if (wr_tia_cfg) begin
            gain_q <= i_wdata[lpbd_pkg::GAIN_LSB +: lpbd_pkg::GAIN_W];
        end
    end

    // Loop switch bits as written by software
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            loop_sw_q <= 14'h0000;
        end else if (wr_loop_sw) begin
            loop_sw_q <= i_wdata[lpbd_pkg::LOOP_SW_N-1:0];
        end
    end

    // Per-switch closure: software bit or automatic force/sense
    genvar sw;
    generate
        for (sw = 0; sw < lpbd_pkg::LOOP_SW_N; sw++) begin : g_sw
            assign loop_sw_d[sw] = loop_sw_q[sw]
                | (lpbd_pkg::FORCE_SENSE_SW[sw] & (|gain_q));
        end
    endgenerate

    // Expected bias voltages, linear between end points
    assign coarse_prod = {34'h0, coarse_q} * lpbd_pkg::COARSE_SPAN;
    assign fine_prod   = {28'h0, fine_q} * lpbd_pkg::FINE_SPAN;
    assign coarse_uv_d = 22'(lpbd_pkg::V_ZERO_UV
                         + coarse_prod / lpbd_pkg::COARSE_STEPS);
    assign fine_uv_d   = 22'(lpbd_pkg::V_ZERO_UV
                         + fine_prod / lpbd_pkg::FINE_STEPS);

    // Registered analog controls
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            analog_q <= '0;
        end else begin
            analog_q.coarse_bias_code            <= coarse_q;
            analog_q.fine_bias_code              <= fine_q;
            analog_q.coarse_bias_uv              <= coarse_uv_d;
            analog_q.fine_bias_uv                <= fine_uv_d;
            analog_q.ref_buffer_powerdown        <= refbuf_pd_q;
            analog_q.bandgap_powerdown           <= bandgap_pd_q;
            analog_q.common_mode_resistor_enable <= cm_en_q;
            analog_q.gain_resistor_select        <= gain_q;
            analog_q.amp_loop_switches           <= loop_sw_d;
            analog_q.diode_clamp_switch          <=
                loop_sw_d[lpbd_pkg::DIODE_SW_BIT];
            analog_q.potentiostat_feedback_switch <=
                loop_sw_d[lpbd_pkg::PSTAT_FB_BIT];
        end
    end

    // Read mux; reserved and unmapped bits read zero
    always_comb begin
        rdata_d = lpbd_pkg::RST_ZERO;
        if (i_rd) begin
            if (hit(i_addr, lpbd_pkg::ADDR_DAC_CODES)) begin
                rdata_d[lpbd_pkg::COARSE_LSB +: lpbd_pkg::COARSE_W] = coarse_q;
                rdata_d[lpbd_pkg::FINE_LSB +: lpbd_pkg::FINE_W] = fine_q;
            end else if (hit(i_addr, lpbd_pkg::ADDR_DAC_CTRL)) begin
                rdata_d[lpbd_pkg::DAC_WE_BIT] = dac_we_q;
            end else if (hit(i_addr, lpbd_pkg::ADDR_REF_PWR)) begin
                rdata_d[lpbd_pkg::REFBUF_PD_BIT]  = refbuf_pd_q;
                rdata_d[lpbd_pkg::BANDGAP_PD_BIT] = bandgap_pd_q;
            end else if (hit(i_addr, lpbd_pkg::ADDR_CM_SW)) begin
                rdata_d[lpbd_pkg::CM_ENABLE_BIT] = cm_en_q;
            end else if (hit(i_addr, lpbd_pkg::ADDR_TIA_CFG)) begin
                rdata_d[lpbd_pkg::GAIN_LSB +: lpbd_pkg::GAIN_W] = gain_q;
            end else if (hit(i_addr, lpbd_pkg::ADDR_LOOP_SW)) begin
                rdata_d[lpbd_pkg::LOOP_SW_N-1:0] = loop_sw_q;
            end
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            rdata_q <= lpbd_pkg::RST_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata  = rdata_q;
    assign o_analog = analog_q;

endmodule

// *** lpbd_regs_chk.sv ***
module lpbd_chk (
    input wire logic                   i_clk,
    input wire logic                   i_nrst,
    input wire logic [15:0]            i_addr,
    input wire logic [31:0]            i_wdata,
    input wire logic                   i_wr,
    input wire logic                   i_rd,
    input wire logic [31:0]            o_rdata,
    input wire lpbd_pkg::lpbd_analog_s o_analog
);
    default clocking dck @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    // Expected bias voltages in microvolts, from the codes shown
    logic [39:0] c_uv;
    logic [39:0] f_uv;
    assign c_uv = lpbd_pkg::V_ZERO_UV + 40'(o_analog.coarse_bias_code)
                  * lpbd_pkg::COARSE_SPAN / lpbd_pkg::COARSE_STEPS;
    assign f_uv = lpbd_pkg::V_ZERO_UV + 40'(o_analog.fine_bias_code)
                  * lpbd_pkg::FINE_SPAN / lpbd_pkg::FINE_STEPS;
    // Register write request and its effect two cycles on
    sequence s_wr(logic [15:0] a);
        i_wr && i_addr == a;
    endsequence
    property p_bit(logic [15:0] a, int b, logic s);
        s_wr(a) |-> ##2 s == $past(i_wdata[b], 2);
    endproperty
    a_coarse_volt: assert property ($past(i_nrst) |->
        o_analog.coarse_bias_uv == c_uv[21:0]) else $error("coarse uv");
    a_fine_volt: assert property ($past(i_nrst) |->
        o_analog.fine_bias_uv == f_uv[21:0]) else $error("fine uv");
    a_coarse_cause: assert property ($past(i_nrst) && $changed(
        {o_analog.coarse_bias_code, o_analog.fine_bias_code})
        |-> $past(i_wr, 2) || $past(i_wr, 3)) else $error("code moved");
    a_refbuf_bit: assert property (p_bit(lpbd_pkg::ADDR_REF_PWR, 1,
        o_analog.ref_buffer_powerdown)) else $error("buffer bit");
    a_bandgap_bit: assert property (p_bit(lpbd_pkg::ADDR_REF_PWR, 0,
        o_analog.bandgap_powerdown)) else $error("bandgap bit");
    a_cm_bit: assert property (p_bit(lpbd_pkg::ADDR_CM_SW, 3,
        o_analog.common_mode_resistor_enable)) else $error("cm bit");
    a_force_sense: assert property (|o_analog.gain_resistor_select |->
        &o_analog.amp_loop_switches[3:2]) else $error("force sense");
    a_clamp_sw: assert property (o_analog.diode_clamp_switch ==
        o_analog.amp_loop_switches[0]) else $error("clamp switch");
    a_fb_sw: assert property (o_analog.potentiostat_feedback_switch ==
        o_analog.amp_loop_switches[10]) else $error("feedback switch");
    a_loop_write: assert property (s_wr(lpbd_pkg::ADDR_LOOP_SW) |-> ##2
        o_analog.amp_loop_switches == ($past(i_wdata[13:0], 2)
        | (|o_analog.gain_resistor_select ? lpbd_pkg::FORCE_SENSE_SW
        : 14'h0))) else $error("loop switches");
    a_dac_lock: assert property (s_wr(lpbd_pkg::ADDR_DAC_CTRL)
        && !i_wdata[0] |-> ##3 o_analog.coarse_bias_code == 6'h0
        && o_analog.fine_bias_code == 12'h0) else $error("codes kept");
endmodule
bind lpbd_regs lpbd_chk u_chk (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_analog(o_analog));

// *** test_low_power_bias_dac_control.sv ***
module test_low_power_bias_dac_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   i_clk   = 1'b0;
    logic                   i_nrst  = 1'b0;
    logic [15:0]            i_addr  = 16'h0;
    logic [31:0]            i_wdata = 32'h0;
    logic                   i_wr    = 1'b0;
    logic                   i_rd    = 1'b0;
    logic [31:0]            o_rdata;
    lpbd_pkg::lpbd_analog_s o_analog;
    int                     mismatches  = 0;
    int                     checks_done = 0;
    logic [15:0]            regs [6] = '{16'h2050, 16'h20ec, 16'h20e4,
                                         16'h2120, 16'h2128, 16'h235c};
    // 40 MHz clock
    always #12.5 i_clk = ~i_clk;
    lpbd_regs DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_analog(o_analog));
    // Compare and count
    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // Read strobe, data checked in the following cycle
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk("rdata", o_rdata, e);
    endtask
    // Let the analog outputs follow the last write
    task automatic settle;
        @(posedge i_clk);
        #1;
    endtask
    task automatic finish_test;
        $display("mismatches %0d checks %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'b1;
        foreach (regs[k]) rd(regs[k], 32'h0);
        chk("zero uv", o_analog.coarse_bias_uv, 32'h30d40);
        wr(16'h2050, 32'hffff_ffff);
        settle;
        chk("pd", {o_analog.ref_buffer_powerdown,
            o_analog.bandgap_powerdown}, 32'h3);
        rd(16'h2050, 32'h3);
        wr(16'h2050, 32'h1);
        settle;
        chk("pd", {o_analog.ref_buffer_powerdown,
            o_analog.bandgap_powerdown}, 32'h1);
        wr(16'h235c, 32'hffff_ffff);
        settle;
        chk("cm", o_analog.common_mode_resistor_enable, 32'h1);
        rd(16'h235c, 32'h8);
        wr(16'h235c, 32'hffff_fff7);
        settle;
        chk("cm", o_analog.common_mode_resistor_enable, 32'h0);
        // Codes locked, then unlocked
        wr(16'h2120, 32'hffff_ffff);
        rd(16'h2120, 32'h0);
        wr(16'h2128, 32'h1);
        wr(16'h2120, 32'hffff_ffff);
        rd(16'h2120, 32'h3_ffff);
        chk("coarse", o_analog.coarse_bias_code, 32'h3f);
        chk("fine", o_analog.fine_bias_code, 32'hfff);
        chk("coarse uv", o_analog.coarse_bias_uv, 32'h24_1a30);
        chk("fine uv", o_analog.fine_bias_uv, 32'h24_9f00);
        wr(16'h2120, 32'h0002_0800);
        settle;
        chk("coarse uv", o_analog.coarse_bias_uv, 32'h13_d6de);
        chk("fine uv", o_analog.fine_bias_uv, 32'h13_d72c);
        wr(16'h2128, 32'h0);
        rd(16'h2120, 32'h0);
        chk("fine", o_analog.fine_bias_code, 32'h0);
        // Loop switches and automatic force/sense
        wr(16'h20e4, 32'hffff_c401);
        settle;
        chk("loop", o_analog.amp_loop_switches, 32'h401);
        chk("clamp", o_analog.diode_clamp_switch, 32'h1);
        chk("fb", o_analog.potentiostat_feedback_switch, 32'h1);
        wr(16'h20ec, 32'h20);
        settle;
        chk("loop", o_analog.amp_loop_switches, 32'h40d);
        chk("gain", o_analog.gain_resistor_select, 32'h1);
        rd(16'h20ec, 32'h20);
        rd(16'h20e4, 32'h401);
        wr(16'h20ec, 32'h0);
        settle;
        chk("loop", o_analog.amp_loop_switches, 32'h401);
        // Unmapped place, then a short reset in mid-run
        wr(16'h2124, 32'hffff_ffff);
        rd(16'h2124, 32'h0);
        @(posedge i_clk);
        i_nrst <= 1'b0;
        @(posedge i_clk);
        i_nrst <= 1'b1;
        rd(16'h2050, 32'h0);
        finish_test;
    end
endmodule
